// >>> rtl/adcctl_defs.svh
// Register offsets, field positions, masks and reset values of the converter control bank
// What this block does
// - Index bits 1:0 pick which data channel takes per-channel register writes.
// - Global registers act on every channel whatever the index holds.
// - Index also selects the two output clock channels for their feature subset.
// - Every register except the override register acts as soon as written.
// - Override settings apply only when software writes one to transfer bit 0.
// - Power mode 00 keeps a converter channel active unless its channel status powers it down or resets it.
// - Power mode 01 gates datapath clocks, resets datapath, disables outputs.
// - Power mode 10 gates datapath clocks and outputs, datapath not reset.
// - Power mode 11 resets datapath and its clocks, disables outputs, serial port untouched.
// - No power mode resets the serial port; only power-on reset does.
// - Enhancement bit 2 enables chopping in the first converter stage.
// - Output mode bit 6 selects reduced-range output standard; clear is standard range.
// - Output mode bit 2 inverts every bit of the serial output stream.
// - Output mode bit 0 resets to one for twos complement; zero gives offset binary.
// - Serial control bit 3 picks normal encode (0) or low encode (1).
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH

`define ADCCTL_ADDR_W        13
`define ADCCTL_DATA_W        8
`define ADCCTL_NUM_CH        2

// Register offsets
`define ADCCTL_OFS_INDEX     13'h0005
`define ADCCTL_OFS_PWR       13'h0008
`define ADCCTL_OFS_ENH       13'h000C
`define ADCCTL_OFS_OMODE     13'h0014
`define ADCCTL_OFS_SODC      13'h0021
`define ADCCTL_OFS_CHST      13'h0022
`define ADCCTL_OFS_XFER      13'h00FF
`define ADCCTL_OFS_OVR       13'h0100
`define ADCCTL_OFS_PULL      13'h0101
`define ADCCTL_OFS_VCM       13'h0102

// Reset values
`define ADCCTL_RST_INDEX     8'h33
`define ADCCTL_RST_PWR       8'h00
`define ADCCTL_RST_ENH       8'h00
`define ADCCTL_RST_OMODE     8'h01
`define ADCCTL_RST_SODC      8'h32
`define ADCCTL_RST_CHST      8'h00
`define ADCCTL_RST_OVR       8'h00
`define ADCCTL_RST_PULL      8'h00
`define ADCCTL_RST_VCM       8'h00
`define ADCCTL_RST_LANE      3'h3

// Writable bits, open bits read as zero
`define ADCCTL_MSK_INDEX     8'h33
`define ADCCTL_MSK_PWR       8'h03
`define ADCCTL_MSK_ENH       8'h04
`define ADCCTL_MSK_OMODE     8'h45
`define ADCCTL_MSK_SODC      8'hFF
`define ADCCTL_MSK_CHST      8'h03
`define ADCCTL_MSK_OVR       8'h77
`define ADCCTL_MSK_PULL      8'h01
`define ADCCTL_MSK_VCM       8'h08

// Index bits of the output clock channels
`define ADCCTL_IDX_FCO_BIT   4
`define ADCCTL_IDX_DCO_BIT   5

// Power mode codes
`define ADCCTL_PM_NORMAL     2'h0
`define ADCCTL_PM_PDN        2'h1
`define ADCCTL_PM_STBY       2'h2
`define ADCCTL_PM_DRST       2'h3

// Field positions
`define ADCCTL_ENH_CHOP_BIT  2
`define ADCCTL_OM_RRNG_BIT   6
`define ADCCTL_OM_INV_BIT    2
`define ADCCTL_OM_TWOS_BIT   0
`define ADCCTL_SO_LSBF_BIT   7
`define ADCCTL_SO_LANE_MSB   6
`define ADCCTL_SO_LANE_LSB   4
`define ADCCTL_SO_LENC_BIT   3
`define ADCCTL_SO_DFRM_BIT   2
`define ADCCTL_SO_NB_10      2'h3
`define ADCCTL_CS_PDN_BIT    0
`define ADCCTL_CS_ORST_BIT   1
`define ADCCTL_OV_EN_BIT     6
`define ADCCTL_OV_RES_MSB    5
`define ADCCTL_OV_RES_LSB    4
`define ADCCTL_OV_RATE_MSB   2
`define ADCCTL_XFER_BIT      0
`define ADCCTL_PULL_BIT      0
`define ADCCTL_VCM_BIT       3

// Values in force while the override is off
`define ADCCTL_RES_FULL      2'h2
`define ADCCTL_RATE_FULL     3'h6

`endif

// >>> rtl/adcctl_pkg.sv
// Types shared by the converter control bank modules
package adcctl_pkg;

   // Decoded serial port access, one per cycle
   typedef struct packed {
      logic        wr;      // Write strobe
      logic        rd;      // Read strobe
      logic [12:0] addr;    // Register offset
      logic [7:0]  wdata;   // Write data
   } adcctl_req_t;

   // Read answer
   typedef struct packed {
      logic        rvalid;  // Read data valid pulse
      logic [7:0]  rdata;   // Read data
   } adcctl_rsp_t;

   // Settings that apply to the whole chip
   typedef struct packed {
      logic        dp_clk_en;  // Datapath clocks running
      logic        dp_rst;     // Datapath held in reset
      logic        clk_rst;    // Datapath clocks held in reset
      logic        out_en;     // Outputs enabled
      logic        chop_en;    // First stage chopping
      logic        lsb_first;  // Serial bit order
      logic [2:0]  lane_mode;  // Serialization code
      logic        low_enc;    // Low encode rate mode
      logic        dbl_frame;  // Double frame mode
      logic        word10;     // 10-bit output words
      logic        ovr_en;     // Override in force
      logic [1:0]  res_code;   // Effective resolution code
      logic [2:0]  rate_code;  // Effective max rate code
      logic        sdio_pd_off;// SDIO pull-down disabled
      logic        vcm_pdn;    // VCM generator powered down
      logic        dco_inv;    // Invert on data clock output
      logic        fco_inv;    // Invert on frame clock output
      logic        dco_rrng;   // Reduced range on data clock output
      logic        fco_rrng;   // Reduced range on frame clock output
   } adcctl_glob_t;

   // Settings of one data channel
   typedef struct packed {
      logic        invert;     // Invert serial stream
      logic        twos;       // Twos complement format
      logic        rrng;       // Reduced range standard
      logic        pdn;        // Channel powered down
      logic        out_rst;    // Channel output logic in reset
      logic        active;     // Channel converting and driving
   } adcctl_chcfg_t;

endpackage : adcctl_pkg

// >>> rtl/adcctl_chan.sv
// Per-channel output configuration decode with its own output register
`include "adcctl_defs.svh"

module adcctl_chan
(
   input  wire logic                  clk,        // 250 MHz clock
   input  wire logic                  arst_n,     // Asynchronous reset, active low
   input  wire logic [7:0]            omode,      // Output mode value of this channel
   input  wire logic [7:0]            chst,       // Channel status value of this channel
   input  wire logic                  glob_on,    // Chip power mode lets outputs run
   output adcctl_pkg::adcctl_chcfg_t  cfg         // Registered channel settings
);

   typedef struct packed {
      adcctl_pkg::adcctl_chcfg_t cfg;
   } adcctl_chan_state_t;

   adcctl_chan_state_t state_reg;
   adcctl_chan_state_t state_next;

   // Decode the channel's fields
   always_comb
   begin
      state_next            = state_reg;
      state_next.cfg.invert = omode[`ADCCTL_OM_INV_BIT];
      state_next.cfg.twos   = omode[`ADCCTL_OM_TWOS_BIT];
      state_next.cfg.rrng   = omode[`ADCCTL_OM_RRNG_BIT];
      state_next.cfg.pdn    = chst[`ADCCTL_CS_PDN_BIT];
      state_next.cfg.out_rst = chst[`ADCCTL_CS_ORST_BIT];
      state_next.cfg.active = glob_on & ~chst[`ADCCTL_CS_PDN_BIT]
                              & ~chst[`ADCCTL_CS_ORST_BIT];
   end

   // Register the settings; reset state matches the register defaults
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg.cfg.invert  <= 1'b0;
         state_reg.cfg.twos    <= 1'b1;
         state_reg.cfg.rrng    <= 1'b0;
         state_reg.cfg.pdn     <= 1'b0;
         state_reg.cfg.out_rst <= 1'b0;
         state_reg.cfg.active  <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign cfg = state_reg.cfg;

endmodule : adcctl_chan

// >>> rtl/adcctl_bank.sv
// Serially programmed control register bank of the dual-channel converter
`include "adcctl_defs.svh"

module adcctl_bank
#(
   parameter int NUM_CH = `ADCCTL_NUM_CH              // Number of data channels
)
(
   input  wire logic                  clk,            // 250 MHz clock
   input  wire logic                  arst_n,         // Power-on reset, asynchronous, active low
   input  wire adcctl_pkg::adcctl_req_t req,          // Decoded serial port access
   output adcctl_pkg::adcctl_rsp_t    rsp,            // Read answer
   output adcctl_pkg::adcctl_glob_t   glob,           // Chip-wide settings
   output adcctl_pkg::adcctl_chcfg_t  chcfg [NUM_CH]  // Per-channel settings
);

   // Number of per-channel output mode copies: data channels plus two clocks
   localparam int NUM_TGT = NUM_CH + 2;
   localparam int TGT_DCO = NUM_CH;
   localparam int TGT_FCO = NUM_CH + 1;

   typedef struct packed {
      logic [7:0]               index;      // Channel index
      logic [7:0]               pwr;        // Power mode
      logic [7:0]               enh;        // Enhancement control
      logic [NUM_TGT-1:0][7:0]  omode;      // Output mode per target
      logic [7:0]               sodc;       // Serial output data control
      logic [NUM_CH-1:0][7:0]   chst;       // Channel power and reset per channel
      logic [7:0]               ovr_stage;  // Override as written
      logic [7:0]               ovr_live;   // Override in force
      logic [7:0]               pull;       // IO pull-down control
      logic [7:0]               vcm;        // Common mode control
      adcctl_pkg::adcctl_rsp_t  rsp;        // Read answer
      adcctl_pkg::adcctl_glob_t glob;       // Chip-wide settings
   } adcctl_bank_state_t;

   adcctl_bank_state_t state_reg;
   adcctl_bank_state_t state_next;

   logic                     wr_hit;
   logic [7:0]               wval;
   logic [NUM_CH-1:0][7:0]   chst_now;
   logic [NUM_TGT-1:0][7:0]  omode_now;
   logic                     glob_on_now;

   // Index bit that selects a given output mode target
   function automatic int adcctl_tgt_bit(input int t);
      int b;
      // Data channels use their own index bit
      b = t;
      if (t == TGT_DCO)
      begin
         b = `ADCCTL_IDX_DCO_BIT;
      end
      else if (t == TGT_FCO)
      begin
         b = `ADCCTL_IDX_FCO_BIT;
      end
      return b;
   endfunction : adcctl_tgt_bit

   // Read value of a local register: the lowest selected target wins
   function automatic logic [7:0] adcctl_local_rd(input logic [7:0] idx,
                                                  input logic [NUM_TGT-1:0][7:0] vals,
                                                  input int ntgt);
      logic [7:0] v;
      logic       found;
      v     = 8'h00;
      found = 1'b0;
      for (int t = 0; t < NUM_TGT; t++)
      begin
         if (!found && (t < ntgt) && idx[adcctl_tgt_bit(t)])
         begin
            v     = vals[t];
            found = 1'b1;
         end
      end
      return v;
   endfunction : adcctl_local_rd

   // Register updates and read path
   always_comb
   begin
      logic [NUM_TGT-1:0][7:0] chst_wide;
      chst_wide   = '0;
      // Every register except the read answer holds unless a write selects it
      state_next  = state_reg;
      wr_hit      = req.wr;
      wval        = req.wdata;
      state_next.rsp.rvalid = 1'b0;

      // Writes act in the cycle they are taken; power modes leave this logic alone
      if (wr_hit)
      begin
         unique case (req.addr)
            `ADCCTL_OFS_INDEX:
            begin
               // New index steers the next access, not this one
               state_next.index = wval & `ADCCTL_MSK_INDEX;
            end
            `ADCCTL_OFS_PWR:
            begin
               // Only the decode below sees the mode; no register is cleared by it
               state_next.pwr = wval & `ADCCTL_MSK_PWR;
            end
            `ADCCTL_OFS_ENH:
            begin
               state_next.enh = wval & `ADCCTL_MSK_ENH;
            end
            `ADCCTL_OFS_OMODE:
            begin
               // Output mode goes to every selected data or clock target
               for (int t = 0; t < NUM_TGT; t++)
               begin
                  if (state_reg.index[adcctl_tgt_bit(t)])
                  begin
                     state_next.omode[t] = wval & `ADCCTL_MSK_OMODE;
                  end
               end
            end
            `ADCCTL_OFS_SODC:
            begin
               state_next.sodc = wval & `ADCCTL_MSK_SODC;
            end
            `ADCCTL_OFS_CHST:
            begin
               // Channel status exists for data channels only
               for (int c = 0; c < NUM_CH; c++)
               begin
                  if (state_reg.index[c])
                  begin
                     state_next.chst[c] = wval & `ADCCTL_MSK_CHST;
                  end
               end
            end
            `ADCCTL_OFS_XFER:
            begin
               // Transfer bit self-clears; it copies the staged override into force
               if (wval[`ADCCTL_XFER_BIT])
               begin
                  state_next.ovr_live = state_reg.ovr_stage;
               end
            end
            `ADCCTL_OFS_OVR:
            begin
               // Staged only; nothing acts until the transfer bit is written
               state_next.ovr_stage = wval & `ADCCTL_MSK_OVR;
            end
            `ADCCTL_OFS_PULL:
            begin
               state_next.pull = wval & `ADCCTL_MSK_PULL;
            end
            `ADCCTL_OFS_VCM:
            begin
               state_next.vcm = wval & `ADCCTL_MSK_VCM;
            end
            default:
            begin
               // Unmapped offset: the write is dropped
               state_next.index = state_reg.index;
            end
         endcase
      end

      // Read answer one cycle after the request; unmapped offsets read zero
      if (req.rd && !req.wr)
      begin
         state_next.rsp.rvalid = 1'b1;
         for (int c = 0; c < NUM_CH; c++)
         begin
            chst_wide[c] = state_reg.chst[c];
         end
         unique case (req.addr)
            `ADCCTL_OFS_INDEX:
            begin
               state_next.rsp.rdata = state_reg.index;
            end
            `ADCCTL_OFS_PWR:
            begin
               state_next.rsp.rdata = state_reg.pwr;
            end
            `ADCCTL_OFS_ENH:
            begin
               state_next.rsp.rdata = state_reg.enh;
            end
            `ADCCTL_OFS_OMODE:
            begin
               // Local register: lowest selected target answers
               state_next.rsp.rdata = adcctl_local_rd(state_reg.index, state_reg.omode, NUM_TGT);
            end
            `ADCCTL_OFS_SODC:
            begin
               state_next.rsp.rdata = state_reg.sodc;
            end
            `ADCCTL_OFS_CHST:
            begin
               // Clock targets hold no channel status, only data channels answer
               state_next.rsp.rdata = adcctl_local_rd(state_reg.index, chst_wide, NUM_CH);
            end
            `ADCCTL_OFS_OVR:
            begin
               // Staged value reads back, not the copy in force
               state_next.rsp.rdata = state_reg.ovr_stage;
            end
            `ADCCTL_OFS_PULL:
            begin
               state_next.rsp.rdata = state_reg.pull;
            end
            `ADCCTL_OFS_VCM:
            begin
               state_next.rsp.rdata = state_reg.vcm;
            end
            default:
            begin
               // Unmapped offsets and the self-clearing transfer bit read zero
               state_next.rsp.rdata = 8'h00;
            end
         endcase
      end

      // Power mode decode
      unique case (state_next.pwr[1:0])
         `ADCCTL_PM_NORMAL:
         begin
            // Channels converting unless their channel status stops them, outputs driven
            state_next.glob.dp_clk_en = 1'b1;
            state_next.glob.dp_rst    = 1'b0;
            state_next.glob.clk_rst   = 1'b0;
            state_next.glob.out_en    = 1'b1;
         end
         `ADCCTL_PM_PDN:
         begin
            // Clocks gated, datapath held in reset
            state_next.glob.dp_clk_en = 1'b0;
            state_next.glob.dp_rst    = 1'b1;
            state_next.glob.clk_rst   = 1'b0;
            state_next.glob.out_en    = 1'b0;
         end
         `ADCCTL_PM_STBY:
         begin
            // Clocks and outputs off, datapath state kept
            state_next.glob.dp_clk_en = 1'b0;
            state_next.glob.dp_rst    = 1'b0;
            state_next.glob.clk_rst   = 1'b0;
            state_next.glob.out_en    = 1'b0;
         end
         `ADCCTL_PM_DRST:
         begin
            // Datapath and its clocks in reset; register port untouched
            state_next.glob.dp_clk_en = 1'b0;
            state_next.glob.dp_rst    = 1'b1;
            state_next.glob.clk_rst   = 1'b1;
            state_next.glob.out_en    = 1'b0;
         end
      endcase

      // Chip-wide settings follow the register values at once
      state_next.glob.chop_en   = state_next.enh[`ADCCTL_ENH_CHOP_BIT];
      state_next.glob.lsb_first = state_next.sodc[`ADCCTL_SO_LSBF_BIT];
      state_next.glob.lane_mode = state_next.sodc[`ADCCTL_SO_LANE_MSB:`ADCCTL_SO_LANE_LSB];
      state_next.glob.low_enc   = state_next.sodc[`ADCCTL_SO_LENC_BIT];
      state_next.glob.dbl_frame = state_next.sodc[`ADCCTL_SO_DFRM_BIT];
      state_next.glob.word10    = (state_next.sodc[1:0] == `ADCCTL_SO_NB_10);

      // Pull-down and common mode generator controls
      state_next.glob.sdio_pd_off = state_next.pull[`ADCCTL_PULL_BIT];
      state_next.glob.vcm_pdn   = state_next.vcm[`ADCCTL_VCM_BIT];

      // Clock targets take invert and range from their own output mode copy
      state_next.glob.dco_inv   = state_next.omode[TGT_DCO][`ADCCTL_OM_INV_BIT];
      state_next.glob.fco_inv   = state_next.omode[TGT_FCO][`ADCCTL_OM_INV_BIT];
      state_next.glob.dco_rrng  = state_next.omode[TGT_DCO][`ADCCTL_OM_RRNG_BIT];
      state_next.glob.fco_rrng  = state_next.omode[TGT_FCO][`ADCCTL_OM_RRNG_BIT];

      // Override acts only from its copy in force
      state_next.glob.ovr_en = state_next.ovr_live[`ADCCTL_OV_EN_BIT];
      if (state_next.ovr_live[`ADCCTL_OV_EN_BIT])
      begin
         state_next.glob.res_code  = state_next.ovr_live[`ADCCTL_OV_RES_MSB:`ADCCTL_OV_RES_LSB];
         state_next.glob.rate_code = state_next.ovr_live[`ADCCTL_OV_RATE_MSB:0];
      end
      else
      begin
         // Override off: full resolution at the top rate code
         state_next.glob.res_code  = `ADCCTL_RES_FULL;
         state_next.glob.rate_code = `ADCCTL_RATE_FULL;
      end

      chst_now    = state_next.chst;
      omode_now   = state_next.omode;
      glob_on_now = state_next.glob.out_en;
   end

   // Register all state; only the power-on reset clears it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg.index     <= `ADCCTL_RST_INDEX;
         state_reg.pwr       <= `ADCCTL_RST_PWR;
         state_reg.enh       <= `ADCCTL_RST_ENH;
         state_reg.omode     <= {NUM_TGT{`ADCCTL_RST_OMODE}};
         state_reg.sodc      <= `ADCCTL_RST_SODC;
         state_reg.chst      <= {NUM_CH{`ADCCTL_RST_CHST}};
         state_reg.ovr_stage <= `ADCCTL_RST_OVR;
         state_reg.ovr_live  <= `ADCCTL_RST_OVR;
         state_reg.pull      <= `ADCCTL_RST_PULL;
         state_reg.vcm       <= `ADCCTL_RST_VCM;
         state_reg.rsp       <= '0;
         // Chip-wide outputs start as the register defaults decode
         state_reg.glob      <= '0;
         state_reg.glob.dp_clk_en <= 1'b1;
         state_reg.glob.out_en    <= 1'b1;
         state_reg.glob.lane_mode <= `ADCCTL_RST_LANE;
         state_reg.glob.res_code  <= `ADCCTL_RES_FULL;
         state_reg.glob.rate_code <= `ADCCTL_RATE_FULL;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // One decode per data channel
   // Fed from next-state values so channel outputs move on the same edge as the bank
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_chan
      adcctl_chan u_chan
      (
         .clk     (clk),
         .arst_n  (arst_n),
         .omode   (omode_now[g]),
         .chst    (chst_now[g]),
         .glob_on (glob_on_now),
         .cfg     (chcfg[g])
      );
   end

   // Outputs come straight from the state register
   assign rsp  = state_reg.rsp;
   assign glob = state_reg.glob;

endmodule : adcctl_bank

// >>> verif/adcctl_bank_properties.sv
// Concurrent checks on the ports of the converter control bank
`include "adcctl_defs.svh"

module adcctl_bank_props
#(
   parameter int NUM_CH = 2                           // Number of data channels
)
(
   input wire logic                      clk,            // Clock
   input wire logic                      arst_n,         // Reset, active low
   input wire adcctl_pkg::adcctl_req_t   req,            // Register access
   input wire adcctl_pkg::adcctl_rsp_t   rsp,            // Read answer
   input wire adcctl_pkg::adcctl_glob_t  glob,           // Chip-wide settings
   input wire adcctl_pkg::adcctl_chcfg_t chcfg [NUM_CH]  // Per-channel settings
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       w_pwr;
   logic       w_enh;
   logic       w_sodc;
   logic [7:0] staged_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Writes of interest
   assign w_pwr = req.wr && req.addr == `ADCCTL_OFS_PWR;
   assign w_enh = req.wr && req.addr == `ADCCTL_OFS_ENH;
   assign w_sodc = req.wr && req.addr == `ADCCTL_OFS_SODC;

   // Copy of the staged override value
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         staged_reg <= 8'h00;
      else if (req.wr && req.addr == `ADCCTL_OFS_OVR)
         staged_reg <= req.wdata;

   property p_pm_run;
      w_pwr && req.wdata[1:0] == 2'h0 |=> glob.dp_clk_en && glob.out_en && !glob.dp_rst && !glob.clk_rst;
   endproperty
   a_pm_run: assert property (p_pm_run) else $error("normal mode not running");
   property p_pm_pdn;
      w_pwr && req.wdata[1:0] == 2'h1 |=> !glob.dp_clk_en && glob.dp_rst && !glob.clk_rst && !glob.out_en;
   endproperty
   a_pm_pdn: assert property (p_pm_pdn) else $error("power-down decode wrong");
   property p_pm_stby;
      w_pwr && req.wdata[1:0] == 2'h2 |=> !glob.dp_clk_en && !glob.dp_rst && !glob.clk_rst && !glob.out_en;
   endproperty
   a_pm_stby: assert property (p_pm_stby) else $error("standby decode wrong");
   property p_pm_drst;
      w_pwr && req.wdata[1:0] == 2'h3 |=> !glob.dp_clk_en && glob.clk_rst && glob.dp_rst && !glob.out_en;
   endproperty
   a_pm_drst: assert property (p_pm_drst) else $error("digital reset decode wrong");
   property p_port_alive;
      req.rd && !req.wr |=> rsp.rvalid;
   endproperty
   a_port_alive: assert property (p_port_alive) else $error("read not answered");
   property p_chop;
      w_enh |=> glob.chop_en == $past(req.wdata[2]);
   endproperty
   a_chop: assert property (p_chop) else $error("chop bit not applied");
   property p_sodc;
      w_sodc |=> {glob.lsb_first, glob.lane_mode, glob.low_enc, glob.dbl_frame} == $past(req.wdata[7:2]);
   endproperty
   a_sodc: assert property (p_sodc) else $error("serial control not applied");
   property p_ovr_load;
      req.wr && req.addr == `ADCCTL_OFS_XFER && req.wdata[0] |=> glob.ovr_en == $past(staged_reg[6]);
   endproperty
   a_ovr_load: assert property (p_ovr_load) else $error("override not loaded");
endmodule : adcctl_bank_props

bind adcctl_bank adcctl_bank_props #(.NUM_CH(NUM_CH)) u_props (.clk(clk), .arst_n(arst_n), .req(req),
   .rsp(rsp), .glob(glob), .chcfg(chcfg));

// >>> verif/adcctl_bank_test.sv
// Self-checking bench for the converter control bank
`include "adcctl_defs.svh"

module adcctl_bank_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                      clk = 1'b0;
   logic                      arst_n = 1'b0;
   adcctl_pkg::adcctl_req_t   req = '0;
   adcctl_pkg::adcctl_rsp_t   rsp;
   adcctl_pkg::adcctl_glob_t  glob;
   adcctl_pkg::adcctl_chcfg_t chcfg [2];
   int                        fails = 0;
   int                        compares = 0;

   // 250 MHz clock
   always #2 clk = ~clk;

   adcctl_bank #(.NUM_CH(2)) uut (.clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp), .glob(glob), .chcfg(chcfg));

   // Compare one value
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   // One write, settled outputs on return
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(posedge clk);
      #1 req.wr = 1'b0;
   endtask : wr

   // One read, answer due one cycle later
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 req.rd = 1'b1;
      req.addr = a;
      @(posedge clk);
      #1 req.rd = 1'b0;
      chk({7'h00, rsp.rvalid}, 8'h01);
      chk(rsp.rdata, exp);
   endtask : rd

   // Serial stream fields, lane code down to bit order
   function automatic logic [7:0] so_view();
      return {glob.lane_mode, glob.low_enc, glob.word10, glob.dbl_frame, glob.lsb_first, 1'b0};
   endfunction : so_view

   // Reset values and an unmapped place
   task automatic t_reset;
      rd(`ADCCTL_OFS_SODC, 8'h32);
      rd(`ADCCTL_OFS_OVR, 8'h00);
      rd(13'h0010, 8'h00);
      rd(`ADCCTL_OFS_XFER, 8'h00);
      chk({7'h00, chcfg[1].twos}, 8'h01);
   endtask : t_reset

   // Every power mode, port stays usable
   task automatic t_power;
      logic [7:0] pm_exp [4] = '{8'h09, 8'h04, 8'h00, 8'h06};
      for (int m = 0; m < 4; m++)
      begin
         wr(`ADCCTL_OFS_PWR, 8'(m));
         chk({4'h0, glob.dp_clk_en, glob.dp_rst, glob.clk_rst, glob.out_en}, pm_exp[m]);
         chk({7'h00, chcfg[0].active}, {7'h00, pm_exp[m][0]});
         rd(`ADCCTL_OFS_SODC, 8'h32);
      end
      wr(`ADCCTL_OFS_PWR, 8'h00);
   endtask : t_power

   // Index steers local writes, global ones ignore it
   task automatic t_index;
      wr(`ADCCTL_OFS_INDEX, 8'h01);
      wr(`ADCCTL_OFS_OMODE, 8'h44);
      chk({5'h00, chcfg[0].rrng, chcfg[0].invert, chcfg[0].twos}, 8'h06);
      chk({5'h00, chcfg[1].rrng, chcfg[1].invert, chcfg[1].twos}, 8'h01);
      wr(`ADCCTL_OFS_INDEX, 8'h30);
      wr(`ADCCTL_OFS_OMODE, 8'h44);
      chk({4'h0, glob.dco_inv, glob.fco_inv, glob.dco_rrng, glob.fco_rrng}, 8'h0F);
      chk({7'h00, chcfg[1].invert}, 8'h00);
      wr(`ADCCTL_OFS_INDEX, 8'h02);
      wr(`ADCCTL_OFS_CHST, 8'h03);
      chk({5'h00, chcfg[1].pdn, chcfg[1].out_rst, chcfg[1].active}, 8'h06);
      chk({7'h00, chcfg[0].pdn}, 8'h00);
      rd(`ADCCTL_OFS_CHST, 8'h03);
      wr(`ADCCTL_OFS_SODC, 8'h4B);
      chk(so_view(), 8'h98);
      wr(`ADCCTL_OFS_SODC, 8'h84);
      chk(so_view(), 8'h06);
   endtask : t_index

   // Override waits for the transfer bit
   task automatic t_override;
      wr(`ADCCTL_OFS_OVR, 8'h63);
      chk({glob.ovr_en, glob.res_code, glob.rate_code, 2'h0}, 8'h58);
      rd(`ADCCTL_OFS_OVR, 8'h63);
      wr(`ADCCTL_OFS_XFER, 8'h00);
      chk({glob.ovr_en, glob.res_code, glob.rate_code, 2'h0}, 8'h58);
      wr(`ADCCTL_OFS_XFER, 8'h01);
      chk({glob.ovr_en, glob.res_code, glob.rate_code, 2'h0}, 8'hCC);
      wr(`ADCCTL_OFS_ENH, 8'hFF);
      chk({7'h00, glob.chop_en}, 8'h01);
      rd(`ADCCTL_OFS_ENH, 8'h04);
      wr(`ADCCTL_OFS_PULL, 8'hFF);
      wr(`ADCCTL_OFS_VCM, 8'hFF);
      chk({6'h00, glob.sdio_pd_off, glob.vcm_pdn}, 8'h03);
      rd(`ADCCTL_OFS_VCM, 8'h08);
   endtask : t_override

   // Mid-run power-on reset brings every register back to its default
   task automatic t_rearm;
      @(posedge clk);
      #1 arst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      chk({glob.ovr_en, glob.res_code, glob.rate_code, 2'h0}, 8'h58);
      chk({7'h00, glob.vcm_pdn}, 8'h00);
      rd(`ADCCTL_OFS_INDEX, 8'h33);
      rd(`ADCCTL_OFS_CHST, 8'h00);
   endtask : t_rearm

   // Counts and verdict
   task automatic tally_and_finish;
      $display("Compares %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      #1 arst_n = 1'b1;
      t_reset;
      t_power;
      t_index;
      t_override;
      t_rearm;
      tally_and_finish;
   end
endmodule : adcctl_bank_test
